// *** shared/lotp_regs.svh ***
`ifndef LOTP_REGS_SVH
`define LOTP_REGS_SVH

// ----------------------------------------------------------------
// register map (stride and addresses in bytes, channel offsets as word index, one word each)
// ----------------------------------------------------------------
`define LOTP_CH_STRIDE   8'h10
`define LOTP_OFS_ASSIGN  2'h0
`define LOTP_OFS_DELAY   2'h1
`define LOTP_OFS_POL     2'h2
`define LOTP_OFS_HOLD    2'h3
`define LOTP_A_APPFN     8'h20
`define LOTP_A_STATUS    8'h24

// ----------------------------------------------------------------
// fields and limits
// ----------------------------------------------------------------
`define LOTP_ASG_W       5
`define LOTP_TIME_W      16
`define LOTP_HOLD_W      14
`define LOTP_APP_FIELD   8
`define LOTP_DELAY_MAX   16'hEA60
`define LOTP_HOLD_MAX    14'h270F
`define LOTP_ASG_NONE    5'h00
`define LOTP_ASG_NOFLT   5'h01
`define LOTP_ASG_LINE    5'h02
`define LOTP_ASG_OUTC    5'h03
`define LOTP_ASG_DCPRE   5'h04
`define LOTP_ASG_DAMPER  5'h05

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LOTP_CLK_NS      100
`define LOTP_TICK_NS     1000000

`endif

// *** shared/lotp_pkg.sv ***
`include "lotp_regs.svh"

package lotp_pkg;

    typedef logic [`LOTP_ASG_W-1:0]  lotp_asg_t;
    typedef logic [`LOTP_TIME_W-1:0] lotp_time_t;

    typedef enum logic [3:0]
    {
        LOTP_OFF       = 4'h1,
        LOTP_ON_WAIT   = 4'h2,
        LOTP_ON        = 4'h4,
        LOTP_HOLD_WAIT = 4'h8
    } lotp_state_t;

    function automatic logic lotp_is_app(input lotp_asg_t a);
        return a inside {`LOTP_ASG_LINE, `LOTP_ASG_OUTC, `LOTP_ASG_DCPRE, `LOTP_ASG_DAMPER};
    endfunction : lotp_is_app

    function automatic logic lotp_lock_delay(input lotp_asg_t a);
        return a inside {`LOTP_ASG_NOFLT, `LOTP_ASG_OUTC, `LOTP_ASG_DCPRE, `LOTP_ASG_LINE};
    endfunction : lotp_lock_delay

    // polarity and hold share the same locked set
    function automatic logic lotp_lock_pol(input lotp_asg_t a);
        return a inside {`LOTP_ASG_NOFLT, `LOTP_ASG_DCPRE, `LOTP_ASG_LINE};
    endfunction : lotp_lock_pol

endpackage : lotp_pkg

// *** shared/lotp_if.sv ***
`timescale 1ns/10ps
interface lotp_if;
    import lotp_pkg::*;
    logic       tick;
    logic       present;
    logic       cond;
    lotp_time_t delay;
    lotp_time_t hold;
    logic       neg;
    logic       active;
    logic       out;

    modport ctl  (output tick, present, cond, delay, hold, neg, input active, out);
    modport chan (input tick, present, cond, delay, hold, neg, output active, out);
endinterface : lotp_if

// *** design/lotp_channel.sv ***
`timescale 1ns/10ps
module lotp_channel
    import lotp_pkg::*;
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // settings in, output state back
    lotp_if.chan      ch
);
    import lotp_pkg::*;

    lotp_state_t state;
    lotp_state_t next_state;
    lotp_time_t  cnt;
    lotp_time_t  next_cnt;
    logic        out_q;

    wire lotp_time_t limit   = (state == LOTP_ON_WAIT) ? ch.delay : ch.hold;
    wire logic       expired = ch.tick && (cnt == limit);
    wire logic       active  = (state == LOTP_ON) || (state == LOTP_HOLD_WAIT);

    // ----------------------------------------------------------------
    // timing state machine
    // ----------------------------------------------------------------
    // a wait ends on the (limit+1)th tick, so the first partial tick
    // never shortens the configured time
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        unique case (state)
            LOTP_OFF:
            begin
                if (ch.cond)
                begin
                    next_state = (ch.delay == '0) ? LOTP_ON : LOTP_ON_WAIT;
                    next_cnt   = '0;
                end
            end
            LOTP_ON_WAIT:
            begin
                if (!ch.cond)
                    next_state = LOTP_OFF;
                else if (expired)
                    next_state = LOTP_ON;
                else if (ch.tick)
                    next_cnt = cnt + 1'b1;
            end
            LOTP_ON:
            begin
                if (!ch.cond)
                begin
                    next_state = (ch.hold == '0) ? LOTP_OFF : LOTP_HOLD_WAIT;
                    next_cnt   = '0;
                end
            end
            LOTP_HOLD_WAIT:
            begin
                if (ch.cond)
                    next_state = LOTP_ON;
                else if (expired)
                    next_state = LOTP_OFF;
                else if (ch.tick)
                    next_cnt = cnt + 1'b1;
            end
            default:
                next_state = LOTP_OFF;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= LOTP_OFF;
            cnt   <= '0;
            out_q <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
            out_q <= ch.present & (active ^ ch.neg);
        end
    end

    assign ch.active = active;
    assign ch.out    = out_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_on_delay;
        $rose(active) && $past(ch.delay) != '0 |-> $past(state == LOTP_ON_WAIT && ch.tick && cnt == ch.delay);
    endproperty
    a_on_delay: assert property (p_on_delay) else $error("output went active before delay ran out");

    property p_zero_delay;
        state == LOTP_OFF && ch.cond && ch.delay == '0 |=> active ##1 out_q == ($past(ch.present) & ~$past(ch.neg));
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay did not switch at once");

    property p_hold;
        $fell(active) && $past(ch.hold) != '0 |-> $past(state == LOTP_HOLD_WAIT && ch.tick && cnt == ch.hold);
    endproperty
    a_hold: assert property (p_hold) else $error("output released before hold ran out");

    property p_restart;
        state == LOTP_ON_WAIT && !ch.cond |=> state == LOTP_OFF && !active;
    endproperty
    a_restart: assert property (p_restart) else $error("delay not abandoned on condition drop");

    property p_polarity;
        ##1 out_q == ($past(ch.present) & ($past(active) ^ $past(ch.neg)));
    endproperty
    a_polarity: assert property (p_polarity) else $error("output level does not follow polarity");

    c_delay_done: cover property (state == LOTP_ON_WAIT ##1 state == LOTP_ON);
    c_hold_done:  cover property (state == LOTP_HOLD_WAIT ##1 state == LOTP_OFF);
    c_retrigger:  cover property (state == LOTP_HOLD_WAIT ##1 state == LOTP_ON);

endmodule : lotp_channel

// *** design/lotp_top.sv ***
// What this block does
// - output turns active only after the full on-delay, 0..60000 ms, default 0
// - on-delay is forced to zero and unwritable for the four locked assignments
// - polarity positive drives 1 when true, negative drives 0; positive default
// - no-fault, precharge and line contactor lock polarity at positive
// - hold time 0..9999 ms, default 0, zero and unwritable for locked ones
// - outputs and their settings exist only while the expansion card is present
// - each output offers the common condition set, default unassigned
// - output drops only after the full hold time once the condition is false
// - contactor and damper assignments come only through the application setting
`timescale 1ns/10ps
`include "lotp_regs.svh"
module lotp_top
    import lotp_pkg::*;
#(
    parameter int TICK_CYCLES = `LOTP_TICK_NS / `LOTP_CLK_NS
)
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // drive conditions and card detect
    input  wire logic [31:0] cond_in,
    input  wire logic        card_present,
    // logic outputs
    output logic             expansion_logic_output_three,
    output logic             expansion_logic_output_four
);
    import lotp_pkg::*;

    localparam int NCH   = 2;
    localparam int PRE_W = $clog2(TICK_CYCLES);

    // a one-cycle prescaler would tick on every edge and leave the counter zero bits wide
    if (TICK_CYCLES < 2)
    begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    // ----------------------------------------------------------------
    // millisecond tick
    // ----------------------------------------------------------------
    logic [PRE_W-1:0] pre;
    logic             tick;
    wire logic        pre_end = (pre == PRE_W'(TICK_CYCLES - 1));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre  <= '0;
            tick <= 1'b0;
        end
        else
        begin
            pre  <= pre_end ? '0 : pre + 1'b1;
            tick <= pre_end;
        end
    end

    // ----------------------------------------------------------------
    // ahb-lite front end
    // ----------------------------------------------------------------
    // reads take one wait state so a read right after a write sees it
    logic       wr_pend;
    logic       rd_pend;
    logic       hit_q;
    logic [7:0] addr_q;
    logic [31:0] rd_word;

    wire logic accept = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            hit_q     <= 1'b0;
            addr_q    <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_pend   <= accept && hwrite;
            rd_pend   <= accept && !hwrite;
            hreadyout <= !(accept && !hwrite);
            if (accept)
            begin
                addr_q <= {haddr[7:2], 2'b00};
                hit_q  <= (haddr[31:8] == 24'h00_0000);
            end
            if (rd_pend)
                hrdata <= rd_word;
        end
    end

    wire logic        wr_ok   = wr_pend && hit_q;
    wire logic [3:0]  row     = addr_q[7:4];
    wire logic [1:0]  col     = addr_q[3:2];
    wire logic        app_wr  = wr_ok && (addr_q == `LOTP_A_APPFN);
    wire logic        stat_rd = hit_q && (addr_q == `LOTP_A_STATUS);

    // ----------------------------------------------------------------
    // per-output settings and conditioning
    // ----------------------------------------------------------------
    lotp_asg_t           asg  [NCH];
    lotp_time_t          dly  [NCH];
    logic [`LOTP_HOLD_W-1:0] hld [NCH];
    logic                neg  [NCH];
    logic [31:0]         ch_rd [NCH];
    logic [NCH-1:0]      act_v;
    logic [NCH-1:0]      out_v;
    logic [NCH-1:0]      cond_v;

    for (genvar c = 0; c < NCH; c++)
    begin : chan_g
        lotp_if ch_if ();

        wire logic      sel     = wr_ok && card_present && (row == 4'(c));
        wire logic      wr_asg  = sel && (col == `LOTP_OFS_ASSIGN);
        wire logic      wr_dly  = sel && (col == `LOTP_OFS_DELAY);
        wire logic      wr_pol  = sel && (col == `LOTP_OFS_POL);
        wire logic      wr_hld  = sel && (col == `LOTP_OFS_HOLD);
        wire lotp_asg_t w_asg   = hwdata[`LOTP_ASG_W-1:0];
        wire lotp_asg_t w_app   = hwdata[c*`LOTP_APP_FIELD +: `LOTP_ASG_W];
        wire logic      app_ok  = app_wr && card_present && (lotp_is_app(w_app) || w_app == `LOTP_ASG_NONE);
        wire lotp_asg_t next_asg = app_ok ? w_app
                                 : (wr_asg && !lotp_is_app(w_asg)) ? w_asg : asg[c];
        // the whole word is range checked so set upper bits cannot alias into a legal time
        wire logic      dly_ok  = wr_dly && (hwdata <= 32'(`LOTP_DELAY_MAX));
        wire logic      hld_ok  = wr_hld && (hwdata <= 32'(`LOTP_HOLD_MAX));
        wire lotp_time_t next_dly = lotp_lock_delay(next_asg) ? '0
                                  : dly_ok ? hwdata[15:0] : dly[c];
        wire logic [`LOTP_HOLD_W-1:0] next_hld = lotp_lock_pol(next_asg) ? '0
                                  : hld_ok ? hwdata[`LOTP_HOLD_W-1:0] : hld[c];
        wire logic      next_neg = !lotp_lock_pol(next_asg) && (wr_pol ? hwdata[0] : neg[c]);

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                asg[c] <= `LOTP_ASG_NONE;
                dly[c] <= '0;
                hld[c] <= '0;
                neg[c] <= 1'b0;
            end
            else
            begin
                asg[c] <= next_asg;
                dly[c] <= next_dly;
                hld[c] <= next_hld;
                neg[c] <= next_neg;
            end
        end

        // code 0 is unassigned; every other code picks its own bit of the shared cond_in
        assign ch_if.cond    = card_present && (asg[c] != `LOTP_ASG_NONE) && cond_in[asg[c]];
        assign ch_if.tick    = tick;
        assign ch_if.present = card_present;
        assign ch_if.delay   = dly[c];
        assign ch_if.hold    = {2'b00, hld[c]};
        assign ch_if.neg     = neg[c];
        assign act_v[c]      = ch_if.active;
        assign out_v[c]      = ch_if.out;
        assign cond_v[c]     = ch_if.cond;

        always_comb
        begin
            ch_rd[c] = 32'h0000_0000;
            unique case (col)
                `LOTP_OFS_ASSIGN: ch_rd[c] = {27'h0, asg[c]};
                `LOTP_OFS_DELAY:  ch_rd[c] = {16'h0000, dly[c]};
                `LOTP_OFS_POL:    ch_rd[c] = {31'h0, neg[c]};
                `LOTP_OFS_HOLD:   ch_rd[c] = {18'h0, hld[c]};
            endcase
        end

        lotp_channel u_chan
        (
            .hclk    (hclk),
            .hresetn (hresetn),
            .ch      (ch_if)
        );

        // ------------------------------------------------------------
        // checks
        // ------------------------------------------------------------
        property p_delay_lock;
            @(posedge hclk) disable iff (!hresetn) lotp_lock_delay(asg[c]) |-> dly[c] == '0;
        endproperty
        a_delay_lock: assert property (p_delay_lock) else $error("locked delay is not zero");

        property p_pol_lock;
            @(posedge hclk) disable iff (!hresetn)
                lotp_lock_pol(asg[c]) && wr_pol |=> !neg[c] && !ch_if.neg;
        endproperty
        a_pol_lock: assert property (p_pol_lock) else $error("locked polarity changed");

        property p_hold_lock;
            @(posedge hclk) disable iff (!hresetn) lotp_lock_pol(asg[c]) |-> hld[c] == '0 && ch_if.hold == '0;
        endproperty
        a_hold_lock: assert property (p_hold_lock) else $error("locked hold time is not zero");

        property p_hold_range;
            @(posedge hclk) disable iff (!hresetn) hld[c] <= `LOTP_HOLD_MAX && dly[c] <= `LOTP_DELAY_MAX;
        endproperty
        a_hold_range: assert property (p_hold_range) else $error("time setting out of range");

        property p_app_only;
            @(posedge hclk) disable iff (!hresetn) wr_asg && lotp_is_app(w_asg) && !app_wr |=> $stable(asg[c]);
        endproperty
        a_app_only: assert property (p_app_only) else $error("contactor code taken from plain setting");

        property p_unassigned;
            @(posedge hclk) disable iff (!hresetn) asg[c] == `LOTP_ASG_NONE |-> !ch_if.cond;
        endproperty
        a_unassigned: assert property (p_unassigned) else $error("unassigned output sees a condition");

        property p_absent;
            @(posedge hclk) disable iff (!hresetn) !card_present ##1 !card_present |-> !ch_if.out;
        endproperty
        a_absent: assert property (p_absent) else $error("output driven without card");

        c_app_assign: cover property (@(posedge hclk) app_ok && w_app == `LOTP_ASG_LINE);
    end

    // ----------------------------------------------------------------
    // read mux and outputs
    // ----------------------------------------------------------------
    wire logic [31:0] status = {25'h0, cond_v, out_v, act_v, card_present};
    wire logic        ch_hit = card_present && (row < 4'(NCH));

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (stat_rd)
            rd_word = status;
        else if (hit_q && ch_hit)
            rd_word = ch_rd[row[0]];
    end

    assign expansion_logic_output_three = out_v[0];
    assign expansion_logic_output_four  = out_v[1];

endmodule : lotp_top

// *** verif/lotp_tb_top.sv ***
`timescale 1ns/10ps
`include "lotp_regs.svh"
module lotp_tb_top;
    import lotp_pkg::*;

    // ----------------------------------------------------------------
    // clock, reset and stimulus
    // ----------------------------------------------------------------
    localparam int TK = 10;
    logic        hclk         = 1'b0;
    logic        hresetn      = 1'b0;
    logic        hsel         = 1'b0;
    logic [31:0] haddr        = 32'h0;
    logic [1:0]  htrans       = 2'h0;
    logic        hwrite       = 1'b0;
    logic [2:0]  hsize        = 3'h2;
    logic [31:0] hwdata       = 32'h0;
    logic [31:0] cond_in      = 32'h0;
    logic        card_present = 1'b1;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        out_three;
    logic        out_four;
    logic        rdy_n;
    logic [31:0] rd_n;
    logic        rsp_n;
    int          err_total    = 0;
    int          cmp_count    = 0;
    int          cyc          = 0;
    int          n;
    logic        ld;
    logic        lp;

    always #50 hclk = ~hclk;

    // ready and read data are registered, so the mid-cycle copy equals the value seen at the next edge
    always @(negedge hclk)
    begin
        rdy_n = hreadyout;
        rd_n  = hrdata;
        rsp_n = hresp;
    end

    lotp_top #(.TICK_CYCLES(TK)) u_dut (
        .hclk                         (hclk),
        .hresetn                      (hresetn),
        .hsel                         (hsel),
        .haddr                        (haddr),
        .htrans                       (htrans),
        .hwrite                       (hwrite),
        .hsize                        (hsize),
        .hwdata                       (hwdata),
        .hready                       (hreadyout),
        .hreadyout                    (hreadyout),
        .hrdata                       (hrdata),
        .hresp                        (hresp),
        .cond_in                      (cond_in),
        .card_present                 (card_present),
        .expansion_logic_output_three (out_three),
        .expansion_logic_output_four  (out_four)
    );

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (rdy_n !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (rdy_n !== 1'b1) @(posedge hclk);
        r = rd_n;
    endtask : bus

    task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_w

    task automatic chk_t(input string nm, input int g, input int lo, input int hi);
        cmp_count++;
        if (g < lo || g > hi)
        begin
            err_total++;
            $display("Error %s expected %0d..%0d cycles seen %0d", nm, lo, hi, g);
        end
    endtask : chk_t

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk_w($sformatf("reg %h", a), e, r);
        chk_w("hresp", 32'h0, {31'h0, rsp_n});
    endtask : rd

    // counts mid-cycle samples until the output reaches lvl, giving up at lim;
    // returns on a rising edge so the next stimulus lands there
    task automatic meas(input logic ch, input logic lvl, input int lim, output int k);
        k = 0;
        do
        begin
            @(negedge hclk);
            k++;
        end
        while (k < lim && (ch ? out_four : out_three) !== lvl);
        @(posedge hclk);
    endtask : meas

    task automatic tally_and_finish();
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a < 8; a++) rd(8'(a * 4), 32'h0);
        rd(8'h28, 32'h0);
        rd(`LOTP_A_STATUS, 32'h1);
        // assignment codes 1 to 5 and what each locks, entered directly or through the application setting
        for (int c = 1; c <= 5; c++)
        begin
            ld = c inside {1, 2, 3, 4};
            lp = c inside {1, 2, 4};
            wr(8'h00, 32'h6);
            wr(8'h04, 32'h7);
            wr(8'h08, 32'h1);
            wr(8'h0C, 32'h7);
            if (c == 1) wr(8'h00, 32'h1);
            else wr(`LOTP_A_APPFN, 32'(c * 257));
            rd(8'h00, 32'(c));
            if (c != 1) rd(8'h10, 32'(c));
            rd(8'h04, ld ? 32'h0 : 32'h7);
            rd(8'h08, lp ? 32'h0 : 32'h1);
            rd(8'h0C, lp ? 32'h0 : 32'h7);
            wr(8'h04, 32'h9);
            wr(8'h0C, 32'h9);
            wr(8'h08, 32'h1);
            rd(8'h04, ld ? 32'h0 : 32'h9);
            rd(8'h0C, lp ? 32'h0 : 32'h9);
            rd(8'h08, lp ? 32'h0 : 32'h1);
        end
        wr(`LOTP_A_APPFN, 32'h0);
        wr(8'h00, 32'h6);
        for (int c = 2; c <= 5; c++) wr(8'h00, 32'(c));
        rd(8'h00, 32'h6);
        // range limits on the second output
        wr(8'h10, 32'h7);
        wr(8'h14, 32'(`LOTP_DELAY_MAX));
        wr(8'h14, 32'(`LOTP_DELAY_MAX) + 32'h1);
        rd(8'h14, 32'(`LOTP_DELAY_MAX));
        wr(8'h1C, 32'(`LOTP_HOLD_MAX));
        wr(8'h1C, 32'(`LOTP_HOLD_MAX) + 32'h1);
        rd(8'h1C, 32'(`LOTP_HOLD_MAX));
        wr(8'h14, 32'h0);
        wr(8'h1C, 32'h0);
        // positive polarity, on-delay 3 ms and hold 2 ms on the first output
        wr(8'h08, 32'h0);
        wr(8'h04, 32'h3);
        wr(8'h0C, 32'h2);
        cond_in[6] <= 1'b1;
        meas(1'b0, 1'b1, 200, n);
        chk_t("on delay", n, 3 * TK, 4 * TK + 3);
        cond_in[6] <= 1'b0;
        meas(1'b0, 1'b0, 200, n);
        chk_t("hold time", n, 2 * TK, 3 * TK + 3);
        cond_in[6] <= 1'b1;
        meas(1'b0, 1'b1, 2 * TK, n);
        chk_t("cut short delay", n, 2 * TK, 2 * TK);
        cond_in[6] <= 1'b0;
        @(posedge hclk);
        cond_in[6] <= 1'b1;
        meas(1'b0, 1'b1, 200, n);
        chk_t("restarted delay", n, 3 * TK, 4 * TK + 3);
        cond_in[6] <= 1'b0;
        repeat (TK) @(posedge hclk);
        cond_in[6] <= 1'b1;
        meas(1'b0, 1'b0, 3 * TK, n);
        chk_t("hold bridged", n, 3 * TK, 3 * TK);
        // zero delay and both polarities on the second output
        cond_in[7] <= 1'b1;
        meas(1'b1, 1'b1, 200, n);
        chk_t("zero delay", n, 1, 3);
        wr(8'h18, 32'h1);
        repeat (3) @(negedge hclk);
        chk_w("active low while true", 32'h0, {31'h0, out_four});
        @(posedge hclk);
        cond_in[7] <= 1'b0;
        meas(1'b1, 1'b1, 200, n);
        chk_t("active low release", n, 1, 3);
        // card removed: outputs low, settings hidden and kept
        card_present <= 1'b0;
        repeat (3) @(negedge hclk);
        chk_w("output without card", 32'h0, {31'h0, out_four});
        @(posedge hclk);
        rd(8'h18, 32'h0);
        wr(8'h14, 32'h5);
        // the first output lost its condition with the card and still sits in its 2 ms hold
        rd(`LOTP_A_STATUS, 32'h2);
        card_present <= 1'b1;
        rd(8'h14, 32'h0);
        rd(8'h18, 32'h1);
        tally_and_finish();
    end

endmodule : lotp_tb_top
